//--- dpg_pkg.sv
package dpg_pkg;
	// ************************************************************
	// widths and fixed values
	// ************************************************************
	localparam int CNT_W = 10; // counter and compare width
	localparam int PSC_W = 3; // prescaler select width
	localparam int DT_W = 8; // dead-time count width
	localparam logic [9:0] CNT_ZERO = 10'h000; // cleared counter
	localparam logic [9:0] CNT_ONE = 10'h001; // counter step
	localparam logic [7:0] DT_ZERO = 8'h00; // no guard interval
	localparam logic [7:0] DT_ONE = 8'h01; // guard step
	localparam logic [7:0] PSC_ONE = 8'h01; // prescale step
	localparam logic [7:0] PSC_ZERO = 8'h00; // prescale start
endpackage : dpg_pkg

//--- dpg_top.sv
// ************************************************************
// dual complementary pwm with guard interval
// ************************************************************
module dpg_top #(
	// counter and compare width
	parameter int CNT_W = dpg_pkg::CNT_W,
	// prescaler select width
	parameter int PSC_W = dpg_pkg::PSC_W,
	// guard countdown width
	parameter int DT_W = dpg_pkg::DT_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// configuration
	input wire logic timer_run_enable_i,
	input wire logic [PSC_W-1:0] prescale_sel_i,
	input wire logic [CNT_W-1:0] period_limit_i,
	input wire logic [CNT_W-1:0] duty_value_i,
	input wire logic primary_output_enable_i,
	input wire logic inverted_output_enable_i,
	input wire logic primary_active_level_i,
	input wire logic inverted_active_level_i,
	input wire logic guard_interval_enable_i,
	input wire logic [DT_W-1:0] dead_time_i,
	// status
	input wire logic period_match_flag_clr_i,
	output logic period_match_flag_o,
	output logic [CNT_W-1:0] period_counter_o,
	// pwm pins
	output logic pwm_true_o,
	output logic pwm_inv_o
);
	// ************************************************************
	// local state
	// ************************************************************
	logic [7:0] psc_cnt_r; // prescale divider count
	logic [7:0] psc_ratio; // decoded ratio
	logic tick; // one increment cycle
	logic [dpg_pkg::CNT_W-1:0] cnt_r; // period counter
	logic [dpg_pkg::CNT_W-1:0] duty_latch_r; // active duty latch
	logic raw_r; // raw modulator level
	logic [dpg_pkg::DT_W-1:0] gd_cnt_r; // guard countdown
	logic raw_d_r; // raw level one cycle ago
	logic guard_on; // dead time is in force
	logic true_act; // true side wants active
	logic inv_act; // inverted side wants active
	logic match_ev; // period boundary this cycle

	// ************************************************************
	// elaboration checks
	// ************************************************************
	// package constants are fixed width, so other sizes are refused
	if (CNT_W != dpg_pkg::CNT_W) begin : cnt_w_chk
		$error("counter width must match the package constants");
	end
	// the prescale divider holds ratios up to 128 only
	if (PSC_W != dpg_pkg::PSC_W) begin : psc_w_chk
		$error("prescale select width must match the divider");
	end
	// guard countdown and its constants share one width
	if (DT_W != dpg_pkg::DT_W) begin : dt_w_chk
		$error("dead-time width must match the package constants");
	end

	// ratio 1,2,4..128 from select code
	function automatic logic [7:0] psc_decode(input logic [PSC_W-1:0] s);
		psc_decode = psc_shift(s);
	endfunction : psc_decode
	// power-of-two ratio keeps the divider a plain compare
	function automatic logic [7:0] psc_shift(input logic [PSC_W-1:0] s);
		psc_shift = dpg_pkg::PSC_ONE << s;
	endfunction : psc_shift

	assign psc_ratio = psc_decode(prescale_sel_i);
	assign tick = timer_run_enable_i
		&& (psc_cnt_r == psc_ratio - dpg_pkg::PSC_ONE);
	assign match_ev = tick && (cnt_r == period_limit_i);
	assign guard_on = guard_interval_enable_i && (dead_time_i != dpg_pkg::DT_ZERO);

	// ************************************************************
	// prescaler
	// ************************************************************
	// held at zero while stopped to save power
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			psc_cnt_r <= dpg_pkg::PSC_ZERO;
		end else if (!timer_run_enable_i || tick) begin
			psc_cnt_r <= dpg_pkg::PSC_ZERO;
		end else begin
			psc_cnt_r <= psc_cnt_r + dpg_pkg::PSC_ONE;
		end
	end

	// ************************************************************
	// period counter
	// ************************************************************
	// advances once per tick; wraps after limit, so period = limit+1
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r <= dpg_pkg::CNT_ZERO;
		end else if (!timer_run_enable_i) begin
			cnt_r <= dpg_pkg::CNT_ZERO;
		end else if (match_ev) begin
			cnt_r <= dpg_pkg::CNT_ZERO;
		end else if (tick) begin
			cnt_r <= cnt_r + dpg_pkg::CNT_ONE;
		end
	end

	// read-only view of the counter
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			period_counter_o <= dpg_pkg::CNT_ZERO;
		end else begin
			period_counter_o <= cnt_r;
		end
	end

	// ************************************************************
	// duty latch and raw modulator
	// ************************************************************
	// new duty only at boundary, so a mid-period write never glitches
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			duty_latch_r <= dpg_pkg::CNT_ZERO;
		end else if (match_ev) begin
			duty_latch_r <= duty_value_i;
		end
	end

	// high from boundary until counter meets duty
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			raw_r <= 1'b0;
		end else if (!timer_run_enable_i) begin
			raw_r <= 1'b0;
		end else if (match_ev) begin
			raw_r <= (duty_value_i != dpg_pkg::CNT_ZERO);
		end else if (tick && cnt_r + dpg_pkg::CNT_ONE == duty_latch_r) begin
			raw_r <= 1'b0;
		end
	end

	// ************************************************************
	// guard interval
	// ************************************************************
	// counts down after each raw edge; both sides idle meanwhile
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			raw_d_r <= 1'b0;
			gd_cnt_r <= dpg_pkg::DT_ZERO;
		end else begin
			raw_d_r <= raw_r;
			if (guard_on && raw_r != raw_d_r) begin
				gd_cnt_r <= dead_time_i;
			end else if (gd_cnt_r != dpg_pkg::DT_ZERO) begin
				gd_cnt_r <= gd_cnt_r - dpg_pkg::DT_ONE;
			end
		end
	end

	// active wishes; edge itself also blocks, so never overlap
	always_comb begin
		true_act = raw_r;
		inv_act = !raw_r && timer_run_enable_i;
		if (guard_on && (gd_cnt_r != dpg_pkg::DT_ZERO || raw_r != raw_d_r)) begin
			true_act = 1'b0;
			inv_act = 1'b0;
		end
	end

	// ************************************************************
	// output stage
	// ************************************************************
	// disabled or stopped pins rest at their inactive level
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwm_true_o <= 1'b0;
			pwm_inv_o <= 1'b0;
		end else begin
			pwm_true_o <= (primary_output_enable_i && true_act)
				? primary_active_level_i : !primary_active_level_i;
			pwm_inv_o <= (inverted_output_enable_i && inv_act)
				? inverted_active_level_i : !inverted_active_level_i;
		end
	end

	// ************************************************************
	// period match flag
	// ************************************************************
	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			period_match_flag_o <= 1'b0;
		end else if (match_ev) begin
			period_match_flag_o <= 1'b1;
		end else if (period_match_flag_clr_i) begin
			period_match_flag_o <= 1'b0;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	stop_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!timer_run_enable_i |=> cnt_r == dpg_pkg::CNT_ZERO)
		else $error("counter not held while stopped");
	wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		match_ev |=> cnt_r == dpg_pkg::CNT_ZERO && period_match_flag_o)
		else $error("boundary did not clear and flag");
	zero_duty_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		match_ev && duty_value_i == dpg_pkg::CNT_ZERO |=> !raw_r)
		else $error("zero duty drove high");
	duty_latch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!match_ev |=> $stable(duty_latch_r))
		else $error("duty latch moved mid period");
	// watched at the pins, one cycle after the wishes were formed
	no_overlap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$past(nrst_i) && $past(guard_on) |->
		!(pwm_true_o == $past(primary_active_level_i)
		&& pwm_inv_o == $past(inverted_active_level_i)))
		else $error("both sides active in guard mode");
	count_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tick && !match_ev |=> cnt_r == $past(cnt_r) + dpg_pkg::CNT_ONE)
		else $error("counter step wrong");
	duty_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tick && !match_ev && cnt_r + dpg_pkg::CNT_ONE == duty_latch_r
		|=> !raw_r)
		else $error("duty match did not drop output");
	true_pol_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!primary_output_enable_i
		|=> pwm_true_o == !$past(primary_active_level_i))
		else $error("disabled true pin not inactive");
	cnt_view_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		1'b1 |=> period_counter_o == $past(cnt_r))
		else $error("counter view wrong");
	boundary_c: cover property (@(posedge clk_i) disable iff (!nrst_i) match_ev);
	guard_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
		guard_on && gd_cnt_r != dpg_pkg::DT_ZERO);
	clr_race_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
		match_ev && period_match_flag_clr_i);
	duty_zero_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
		match_ev && duty_value_i == dpg_pkg::CNT_ZERO);

	// ************************************************************
	// checks on flag and timebase
	// ************************************************************
	// a clear in the boundary cycle must not lose the event
	set_wins_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		match_ev && period_match_flag_clr_i |=> period_match_flag_o)
		else $error("flag lost to a clear at the boundary");
	// sticky until software clears it
	flag_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		period_match_flag_o && !period_match_flag_clr_i
		|=> period_match_flag_o)
		else $error("flag dropped without a clear");
	// divider idles at zero so a restart begins a whole tick
	psc_stop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!timer_run_enable_i |=> psc_cnt_r == dpg_pkg::PSC_ZERO)
		else $error("prescaler ran while stopped");

	// ************************************************************
	// checks on modulator and guard
	// ************************************************************
	// nonzero duty starts each period with the raw level high
	raw_rise_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		match_ev && duty_value_i != dpg_pkg::CNT_ZERO |=> raw_r)
		else $error("boundary did not raise the output");
	// each raw edge reloads the full guard count
	guard_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		guard_on && raw_r != raw_d_r
		|=> gd_cnt_r == $past(dead_time_i))
		else $error("guard count not loaded at edge");
	// inverted side never wakes while the timer is stopped
	inv_stop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!timer_run_enable_i
		|=> pwm_inv_o == !$past(inverted_active_level_i))
		else $error("inverted pin active while stopped");
endmodule : dpg_top

//--- dpg_top_test.sv
module dpg_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// stimulus and observed signals
	// ************************************************************
	logic clk_i = 1'b0, nrst_i = 1'b0, run = 1'b0, pe = 1'b1, ie = 1'b1;
	logic pl = 1'b1, il = 1'b1, ge = 1'b0, fclr = 1'b0;
	logic [2:0] psc = 3'h0;
	logic [9:0] lim = 10'h003, duty = 10'h001;
	logic [7:0] dt = 8'h00;
	logic flag, pt, pi;
	logic [9:0] cnt;
	int miscompares = 0, n_checks = 0, cycles = 0;
	dpg_top dpg_top_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.timer_run_enable_i(run), .prescale_sel_i(psc),
		.period_limit_i(lim), .duty_value_i(duty),
		.primary_output_enable_i(pe), .inverted_output_enable_i(ie),
		.primary_active_level_i(pl), .inverted_active_level_i(il),
		.guard_interval_enable_i(ge), .dead_time_i(dt),
		.period_match_flag_clr_i(fclr), .period_match_flag_o(flag),
		.period_counter_o(cnt), .pwm_true_o(pt), .pwm_inv_o(pi));
	// ************************************************************
	// clock, reset and hang guard
	// ************************************************************
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// a hang ends the run through the same report
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	// one comparison, counted and reported
	task automatic check(input int got, input int exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %0d, expected %0d", $time, got, exp);
		end
	endtask : check
	// stop first so the new setup never meets a running count
	task automatic start(input logic [2:0] p, input logic [9:0] l,
		input logic [9:0] d);
		@(negedge clk_i);
		run = 1'b0;
		psc = p;
		lim = l;
		duty = d;
		@(negedge clk_i);
		run = 1'b1;
		repeat (2 * ((int'(l) + 1) << p) + 4) @(negedge clk_i);
	endtask : start
	// window is whole periods, so its phase does not matter
	task automatic measure(input int n, input int et, input int ei);
		int nt, ni, nb, ov;
		nt = 0;
		ni = 0;
		nb = 0;
		ov = 0;
		repeat (n) begin
			@(negedge clk_i);
			nt += int'(pt === pl);
			ni += int'(pi === il);
			nb += int'(pt === pl && pi === il);
			ov += int'(cnt > lim);
		end
		check(nt, et);
		check(ni, ei);
		check(ov, 0);
		if (ge) check(nb, 0);
	endtask : measure
	// closing report
	task automatic results();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		check(int'(cnt === 10'h000), 1);
		measure(20, 0, 0);
		start(3'h0, 10'h003, 10'h001);
		measure(40, 10, 30);
		pl = 1'b0;
		start(3'h2, 10'h009, 10'h003);
		measure(160, 48, 112);
		start(3'h0, 10'h007, 10'h000);
		measure(32, 0, 32);
		ie = 1'b0;
		pl = 1'b1;
		start(3'h1, 10'h004, 10'h002);
		measure(30, 12, 0);
		ie = 1'b1;
		ge = 1'b1;
		dt = 8'h02;
		start(3'h0, 10'h00f, 10'h005);
		measure(64, 8, 32);
		duty = 10'h009;
		repeat (20) @(negedge clk_i);
		measure(64, 24, 16);
		ge = 1'b0;
		@(negedge clk_i);
		run = 1'b0;
		lim = 10'h3ff;
		duty = 10'h064;
		@(negedge clk_i);
		run = 1'b1;
		repeat (10) @(negedge clk_i);
		fclr = 1'b1;
		@(negedge clk_i);
		fclr = 1'b0;
		check(int'(flag === 1'b0), 1);
		check(int'(cnt > 10'h005 && cnt < 10'h010), 1);
		repeat (1024) @(negedge clk_i);
		check(int'(flag === 1'b1), 1);
		run = 1'b0;
		repeat (3) @(negedge clk_i);
		check(int'(cnt === 10'h000), 1);
		measure(20, 0, 0);
		results();
	end
endmodule : dpg_top_test
